// ===== core/tac_pkg.sv
// package for the type a timer control block: offsets, fields, resets
// assumes an apb slave at 32-bit aligned word offsets
package tac_pkg;
  localparam logic [7:0] TAC_OFF_CTRL = 8'h00;
  localparam logic [7:0] TAC_OFF_COUNT = 8'h04;
  localparam logic [7:0] TAC_OFF_PERIOD = 8'h08;
  localparam int TAC_BIT_ON = 15;
  localparam int TAC_BIT_IDLE = 13;
  localparam int TAC_BIT_WBLK = 12;
  localparam int TAC_BIT_WIP = 11;
  localparam int TAC_BIT_GATE = 7;
  localparam int TAC_BIT_PS_LO = 4;
  localparam int TAC_BIT_SYNC = 2;
  localparam int TAC_BIT_CS = 1;
  localparam logic [31:0] TAC_CTRL_WMASK = 32'h0000_b0b6;
  localparam logic [15:0] TAC_CTRL_RESET = 16'h0000;
  localparam logic [15:0] TAC_PERIOD_RESET = 16'hffff;
  localparam logic [1:0] TAC_SYNC_STAGES = 2'h2;
  localparam logic [7:0] TAC_DIV_1 = 8'h00;
  localparam logic [7:0] TAC_DIV_8 = 8'h07;
  localparam logic [7:0] TAC_DIV_64 = 8'h3f;
  localparam logic [7:0] TAC_DIV_256 = 8'hff;
  typedef enum logic [1:0] {
    TAC_W_IDLE = 2'b00,
    TAC_W_SYNC = 2'b01,
    TAC_W_DONE = 2'b11
  } tac_wr_e;
  typedef struct packed {
    logic on;
    logic idle_stop;
    logic async_write_block;
    logic gate_accumulate_en;
    logic [1:0] prescale_select;
    logic sync_en;
    logic clock_source_select;
  } tac_ctrl_s;
endpackage

// ===== core/tac_prescale.sv
// prescaler: turns count ticks into advance pulses per the selected ratio
// assumes tick_in is sampled on pclk; each cycle it is high counts as one tick
`timescale 1ns/1ps
module tac_prescale
  import tac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic tick_in,
  input wire logic [1:0] prescale_select,
  output logic tick_out
);
  import tac_pkg::*;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] limit;
  logic wrap;
  // ratio decode
  assign limit = (prescale_select == 2'h3) ? TAC_DIV_256 :
                 (prescale_select == 2'h2) ? TAC_DIV_64 :
                 (prescale_select == 2'h1) ? TAC_DIV_8 : TAC_DIV_1;
  assign wrap = run && tick_in && (cnt_q >= limit);
  assign cnt_d = !run ? 8'h00 : !tick_in ? cnt_q : wrap ? 8'h00 : cnt_q + 8'h01;
  assign tick_out = wrap;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_d;
  end
  div8_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run && prescale_select == 2'h1 && tick_out) ##1
    (run && prescale_select == 2'h1 && tick_in)[*7] |-> !tick_out)
    else $error("prescale 1:8 produced early pulse");
endmodule // tac_prescale

// ===== core/tac_timer.sv
// type a timer control register with a 16-bit count and period over apb
// assumes an apb master on pclk; ext_clk and gate_in synchronous to pclk
// What this block does
// - the timer counts only while the enable bit 15 is set.
// - bits 31-16, 14, 10-8, 6, 3 and 0 of the control register read as zero.
// - with idle-stop bit 13 set the timer halts while idle is asserted.
// - with write-block bit 12 set, count writes during a pending async write are dropped.
// - with write-block clear, back-to-back count writes are all accepted.
// - in async mode bit 11 reads one while a count write is crossing, else zero.
// - in synchronous mode bit 11 always reads zero.
// - with the external source selected the gate enable bit 7 is ignored.
// - with the internal source, bit 7 turns gated accumulation on or off.
// - prescale bits 5-4 divide by 256, 64, 8 or 1 for codes 11, 10, 01, 00.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module tac_timer
  import tac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic idle_mode,
  input wire logic ext_clk_tick,
  input wire logic gate_in,
  output logic [15:0] timer_count,
  output logic period_match
);
  import tac_pkg::*;
  tac_ctrl_s ctrl_q;
  tac_ctrl_s ctrl_d;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [15:0] period_q;
  logic [15:0] pend_val_q;
  logic [1:0] sync_cnt_q;
  tac_wr_e wr_q;
  tac_wr_e wr_d;
  logic match_q;
  logic [31:0] rdata_q;
  logic acc;
  logic wr_ctrl;
  logic wr_count;
  logic wr_period;
  logic rd_any;
  logic hit;
  logic async_mode;
  logic pending;
  logic count_wr_ok;
  logic run;
  logic gate_mode;
  logic src_tick;
  logic pre_tick;
  logic adv;
  logic wrap;
  logic [31:0] ctrl_rd;
  logic pend_load;
  logic [15:0] period_d;
  logic [15:0] pend_val_d;
  logic [1:0] sync_cnt_d;
  logic [31:0] rdata_d;

  // apb decode
  assign acc = psel && penable;
  assign hit = (paddr == TAC_OFF_CTRL) || (paddr == TAC_OFF_COUNT) ||
               (paddr == TAC_OFF_PERIOD);
  assign wr_ctrl = acc && pwrite && (paddr == TAC_OFF_CTRL);
  assign wr_count = acc && pwrite && (paddr == TAC_OFF_COUNT);
  assign wr_period = acc && pwrite && (paddr == TAC_OFF_PERIOD);
  assign rd_any = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata = rdata_q;

  // async write tracking
  assign async_mode = ctrl_q.clock_source_select && !ctrl_q.sync_en;
  assign pending = (wr_q == TAC_W_SYNC);
  assign count_wr_ok = wr_count && !(ctrl_q.async_write_block && pending);

  // control readback, unused bits zero
  always_comb
  begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[TAC_BIT_ON] = ctrl_q.on;
    ctrl_rd[TAC_BIT_IDLE] = ctrl_q.idle_stop;
    ctrl_rd[TAC_BIT_WBLK] = ctrl_q.async_write_block;
    ctrl_rd[TAC_BIT_WIP] = async_mode && pending;
    ctrl_rd[TAC_BIT_GATE] = ctrl_q.gate_accumulate_en;
    ctrl_rd[TAC_BIT_PS_LO+1] = ctrl_q.prescale_select[1];
    ctrl_rd[TAC_BIT_PS_LO] = ctrl_q.prescale_select[0];
    ctrl_rd[TAC_BIT_SYNC] = ctrl_q.sync_en;
    ctrl_rd[TAC_BIT_CS] = ctrl_q.clock_source_select;
  end

  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
    begin
      ctrl_d.on = pwdata[TAC_BIT_ON];
      ctrl_d.idle_stop = pwdata[TAC_BIT_IDLE];
      ctrl_d.async_write_block = pwdata[TAC_BIT_WBLK];
      ctrl_d.gate_accumulate_en = pwdata[TAC_BIT_GATE];
      ctrl_d.prescale_select = pwdata[TAC_BIT_PS_LO+1:TAC_BIT_PS_LO];
      ctrl_d.sync_en = pwdata[TAC_BIT_SYNC];
      ctrl_d.clock_source_select = pwdata[TAC_BIT_CS];
    end
  end

  // count enable chain
  assign run = ctrl_q.on && !(ctrl_q.idle_stop && idle_mode);
  assign gate_mode = ctrl_q.gate_accumulate_en && !ctrl_q.clock_source_select;
  assign src_tick = ctrl_q.clock_source_select ? ext_clk_tick :
                    (gate_mode ? gate_in : 1'b1);

  tac_prescale u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .tick_in(src_tick),
    .prescale_select(ctrl_q.prescale_select),
    .tick_out(pre_tick)
  );

  assign adv = run && pre_tick;
  assign wrap = adv && (count_q == period_q);

  // write state machine for async count loads
  always_comb
  begin
    wr_d = wr_q;
    case (wr_q)
      TAC_W_IDLE: if (count_wr_ok && async_mode) wr_d = TAC_W_SYNC;
      TAC_W_SYNC: if (sync_cnt_q == TAC_SYNC_STAGES - 2'h1 && !count_wr_ok) wr_d = TAC_W_DONE;
      TAC_W_DONE: wr_d = (count_wr_ok && async_mode) ? TAC_W_SYNC : TAC_W_IDLE;
      default: wr_d = TAC_W_IDLE;
    endcase
  end

  always_comb
  begin
    count_d = count_q;
    if (wr_q == TAC_W_SYNC && wr_d == TAC_W_DONE)
      count_d = pend_val_q;
    else if (count_wr_ok && !async_mode)
      count_d = pwdata[15:0];
    else if (wrap)
      count_d = 16'h0000;
    else if (adv)
      count_d = count_q + 16'h0001;
  end

  // register next values
  assign pend_load = count_wr_ok && async_mode;
  assign period_d = wr_period ? pwdata[15:0] : period_q;
  assign pend_val_d = pend_load ? pwdata[15:0] : pend_val_q;
  assign sync_cnt_d = (count_wr_ok || !pending) ? 2'h0 : sync_cnt_q + 2'h1;
  assign rdata_d = !rd_any ? rdata_q :
                   (paddr == TAC_OFF_CTRL) ? ctrl_rd :
                   (paddr == TAC_OFF_COUNT) ? {16'h0000, count_q} :
                   (paddr == TAC_OFF_PERIOD) ? {16'h0000, period_q} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= tac_ctrl_s'(8'h00);
    else
      ctrl_q <= ctrl_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_q <= TAC_CTRL_RESET;
    else
      count_q <= count_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      period_q <= TAC_PERIOD_RESET;
    else
      period_q <= period_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_val_q <= 16'h0000;
    else
      pend_val_q <= pend_val_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_cnt_q <= 2'h0;
    else
      sync_cnt_q <= sync_cnt_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wr_q <= TAC_W_IDLE;
    else
      wr_q <= wr_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      match_q <= 1'b0;
    else
      match_q <= wrap;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= rdata_d;
  end

  assign timer_count = count_q;
  assign period_match = match_q;

  stop_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_q.on && !wr_count && !pending) |=> $stable(count_q))
    else $error("count moved while disabled");

  rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_rd & ~TAC_CTRL_WMASK & ~(32'h1 << TAC_BIT_WIP)) == 32'h0)
    else $error("reserved control bit read as one");

  idle_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.idle_stop && idle_mode) |-> !adv)
    else $error("timer advanced in idle with idle stop");

  wr_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.async_write_block && pending && wr_count) |=> $stable(pend_val_q))
    else $error("blocked count write was taken");

  wr_b2b_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_q.async_write_block && wr_count && async_mode) |=>
    (pend_val_q == $past(pwdata[15:0])))
    else $error("back to back write lost");

  wip_async_a: assert property (@(posedge pclk) disable iff (!presetn)
    (async_mode && count_wr_ok && !$past(count_wr_ok)) |=>
    ctrl_rd[TAC_BIT_WIP] ##[1:4] !ctrl_rd[TAC_BIT_WIP])
    else $error("write in progress flag wrong");

  wip_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
    !async_mode |-> !ctrl_rd[TAC_BIT_WIP])
    else $error("write in progress set in sync mode");

  gate_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.clock_source_select && run && ext_clk_tick &&
    ctrl_q.prescale_select == 2'h0) |-> adv)
    else $error("gate affected external source");

  gate_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (gate_mode && !gate_in) |-> !adv)
    else $error("count advanced with gate low");

  off_noadv_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q.on |-> !adv)
    else $error("count advanced while disabled");

  idle_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.on && !ctrl_q.idle_stop && idle_mode && !ctrl_q.clock_source_select &&
    !ctrl_q.gate_accumulate_en && ctrl_q.prescale_select == 2'h0) |-> adv)
    else $error("timer stalled in idle without idle stop");

  wip_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (async_mode && count_wr_ok) |=> ctrl_rd[TAC_BIT_WIP])
    else $error("write in progress not raised");

  wr_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pending && wr_d == TAC_W_DONE) |=> (count_q == $past(pend_val_q)))
    else $error("pending count value not loaded");

  ext_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.clock_source_select && !ext_clk_tick) |-> !adv)
    else $error("count advanced without external tick");

  int_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run && !ctrl_q.clock_source_select && !ctrl_q.gate_accumulate_en &&
    ctrl_q.prescale_select == 2'h0) |-> adv)
    else $error("ungated internal count stalled");

  gate_go_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run && gate_mode && gate_in && ctrl_q.prescale_select == 2'h0) |-> adv)
    else $error("gated count stalled with gate high");

  upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:16] == 16'h0000)
    else $error("upper read data bits not zero");

  b2b_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_q.async_write_block && pending && wr_count) |=> pending)
    else $error("back to back write did not restart");
endmodule // tac_timer

// ===== dv/tac_timer_tb.sv
// self-checking bench for the type a timer control block
// assumes tac_timer with zero wait state apb; bench drives every port itself
`timescale 1ns/1ps
module tac_timer_tb;
  import tac_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, period_match;
  logic idle_mode = 1'b0, ext_clk_tick = 1'b0, gate_in = 1'b0, ext_run = 1'b0;
  logic [15:0] timer_count;
  logic [31:0] m = 32'h0;
  int err_total = 0, n_tests = 0, cyc = 0;
  int divs [4] = '{1, 8, 64, 256};
  tac_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .idle_mode(idle_mode), .ext_clk_tick(ext_clk_tick),
    .gate_in(gate_in), .timer_count(timer_count), .period_match(period_match));
  always #10 pclk = ~pclk;
  // external tick every second cycle
  always @(posedge pclk) ext_clk_tick <= ext_run & ~ext_clk_tick;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("counts: %0d checks, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk32(input string s, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic chk16(input string s, input logic [15:0] x, input logic [15:0] g);
    n_tests++;
    if (g !== x)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", s, x, g);
    end
  endtask
  // one transfer, called just after an edge; leaves the bus held
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
  endtask
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    idle();
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    idle();
  endtask
  // count advance over k cycles after settling
  task automatic cnt(input string s, input int k, input logic [15:0] x);
    logic [15:0] a;
    repeat (4) @(negedge pclk);
    a = timer_count;
    repeat (k) @(negedge pclk);
    chk16(s, x, timer_count - a);
    @(posedge pclk);
  endtask
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(TAC_OFF_CTRL);
    chk32("ctrl reset", 32'h0, r);
    rd(TAC_OFF_PERIOD);
    chk32("period reset", {16'h0, TAC_PERIOD_RESET}, r);
    wr(TAC_OFF_CTRL, 32'hffff_ffff);
    rd(TAC_OFF_CTRL);
    chk32("ctrl mask", 32'h0000_b0b6, r);
    $display("test reset and mask done");
    for (int i = 0; i < 4; i++)
    begin
      wr(TAC_OFF_CTRL, 32'h8000 | (i << 4));
      cnt("prescale", 2 * divs[i], 16'h2);
    end
    wr(TAC_OFF_CTRL, 32'h0);
    cnt("off", 20, 16'h0);
    $display("test enable and prescale done");
    idle_mode <= 1'b1;
    wr(TAC_OFF_CTRL, 32'ha000);
    cnt("idle stop", 20, 16'h0);
    wr(TAC_OFF_CTRL, 32'h8000);
    cnt("idle run", 20, 16'd20);
    idle_mode <= 1'b0;
    wr(TAC_OFF_CTRL, 32'h8080);
    cnt("gate low", 20, 16'h0);
    gate_in <= 1'b1;
    cnt("gate high", 20, 16'd20);
    gate_in <= 1'b0;
    wr(TAC_OFF_CTRL, 32'h8000);
    cnt("gate off", 20, 16'd20);
    ext_run <= 1'b1;
    wr(TAC_OFF_CTRL, 32'h8086);
    cnt("ext gate ignored", 20, 16'd10);
    ext_run <= 1'b0;
    $display("test idle gate source done");
    wr(TAC_OFF_CTRL, 32'h1002);
    apb(1'b1, TAC_OFF_COUNT, 32'h1234);
    apb(1'b0, TAC_OFF_CTRL, 32'h0);
    idle();
    chk32("pending set", 32'h0000_1802, r);
    repeat (6) @(posedge pclk);
    rd(TAC_OFF_CTRL);
    chk32("pending clear", 32'h0000_1002, r);
    rd(TAC_OFF_COUNT);
    chk32("async load", 32'h1234, r);
    for (int b = 1; b >= 0; b--)
    begin
      wr(TAC_OFF_CTRL, 32'h0002 | (b << 12));
      apb(1'b1, TAC_OFF_COUNT, 32'h5555);
      apb(1'b1, TAC_OFF_COUNT, 32'h6666);
      idle();
      repeat (6) @(posedge pclk);
      chk16("back to back", (b == 1) ? 16'h5555 : 16'h6666, timer_count);
    end
    $display("test async write done");
    wr(8'h0c, 32'hffff_ffff);
    chk32("unmapped write err", 32'h1, {31'h0, e});
    rd(8'h0c);
    chk32("unmapped read", 32'h1, {31'h0, e});
    chk32("unmapped data", 32'h0, r);
    rd(TAC_OFF_CTRL);
    chk32("ctrl kept", 32'h0000_0002, r);
    $display("test unmapped done");
    wr(TAC_OFF_PERIOD, 32'h3);
    wr(TAC_OFF_COUNT, 32'h0);
    wr(TAC_OFF_CTRL, 32'h8000);
    repeat (4) @(negedge pclk);
    repeat (16) @(negedge pclk) m += {31'h0, period_match};
    @(posedge pclk);
    chk32("period match", 32'd4, m);
    $display("test period match done");
    give_verdict();
  end
endmodule // tac_timer_tb
